// file: verilog/scp_defines.svh
// Constants of the serial control port and pin logic of the waveform synthesizer.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

`define SCP_NREG          4
`define SCP_AW            2
`define SCP_DW            32
`define SCP_CNT_W         6
`define SCP_INSTR_LAST    6'h07
`define SCP_DATA_LAST     6'h1F
`define SCP_RW_BIT        7
`define SCP_REG_CTRL      2'h0
`define SCP_REG_FREQ      2'h1
`define SCP_REG_PHASE     2'h2
`define SCP_REG_AMP       2'h3
`define SCP_CTRL_CLR      0
`define SCP_CTRL_KEY_EN   1
`define SCP_CTRL_PWRDN    2
`define SCP_BUF_RST       32'h00000000
`define SCP_CTRL_ACT_RST  32'h00000001
`define SCP_ACT_RST       32'h00000000
`define SCP_PH_W          14
`define SCP_PH_LSB        18
`define SCP_NPIN          11
`define SCP_PIN_RST       11'h200
`define SCP_FREQ_LAT      24
`define SCP_AMP_LAT       16

`endif

// file: verilog/scp_pkg.sv
// Types shared by the serial control port and pin logic.
`default_nettype none
package scp_pkg;
  typedef enum logic [2:0] {
    SCP_IDLE  = 3'h1,
    SCP_INSTR = 3'h2,
    SCP_DATA  = 3'h4
  } scp_state_t;
  typedef logic [31:0] scp_word_t;
  typedef logic [13:0] scp_ph_t;
endpackage
`default_nettype wire

// file: verilog/scp_sync.sv
// Two-flop synchroniser bank for pins arriving from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module scp_sync #(
  parameter int                    W       = 1,
  parameter logic [W-1:0]          RST_VAL = '0
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [W-1:0]        d,
  output logic      [W-1:0]        q
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= RST_VAL[i];
          q[i]    <= RST_VAL[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/scp_top.sv
// Serial control port, update strobe, timing output and control pins of the synthesizer.
`timescale 1ns/100ps
`default_nettype none
`include "scp_defines.svh"
module scp_top (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          hw_reset,
  input  wire logic          serial_port_abort,
  input  wire logic          chip_select_n,
  input  wire logic          serial_clock,
  input  wire logic          sdio_in,
  output logic               sdio_out,
  output logic               sdio_oe,
  output logic               serial_out,
  input  wire logic          three_wire_mode,
  input  wire logic          register_update_strobe,
  input  wire logic          oscillator_select,
  output logic               osc_enable,
  output logic               osc_bypass,
  input  wire logic          multichip_align_in,
  input  wire logic          sync_slave_mode,
  output logic               core_timing_out,
  input  wire logic          keying_direction,
  output logic               keying_ramp_up,
  input  wire logic          powerdown_pin,
  output logic               power_down,
  output scp_pkg::scp_word_t freq_word,
  output scp_pkg::scp_ph_t   phase_out,
  output scp_pkg::scp_ph_t   amp_out,
  output logic               phase_clear
);
  import scp_pkg::*;

  logic                       rst_a;
  logic                       rst_n;
  logic                       sp_a;
  logic                       sp_rst_n;
  logic [`SCP_NPIN-1:0]       pin_s;
  logic                       hw_rst_s;
  logic                       cs_s;
  logic                       sclk_s;
  logic                       sdio_s;
  logic                       osc_s;
  logic                       align_s;
  logic                       key_s;
  logic                       pd_s;
  logic                       upd_s;
  logic                       three_wire_s;
  logic                       slave_s;
  logic                       sclk_prev;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       align_prev;
  logic                       align_rise;
  logic                       div;
  logic                       sync_en;
  logic                       upd_ct;
  logic                       upd_pulse;
  scp_state_t                 state;
  logic [`SCP_CNT_W-1:0]      cnt;
  logic [7:0]                 instr;
  scp_word_t                  shin;
  scp_word_t                  rd_shift;
  logic                       sdo_q;
  logic                       wr_en;
  logic [`SCP_AW-1:0]         wr_addr;
  scp_word_t                  wr_data;
  scp_word_t                  buf_q [`SCP_NREG];
  scp_word_t                  act_q [`SCP_NREG];
  scp_word_t                  phase_acc;

  // Reset release is synchronised so no flop sees a runt recovery edge.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  always_ff @(posedge mclk or negedge arst_n or posedge serial_port_abort) begin
    if (!arst_n || serial_port_abort) begin
      sp_a     <= 1'b0;
      sp_rst_n <= 1'b0;
    end else begin
      sp_a     <= 1'b1;
      sp_rst_n <= sp_a;
    end
  end

  scp_sync #(
    .W       (`SCP_NPIN),
    .RST_VAL (`SCP_PIN_RST)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({hw_reset, chip_select_n, serial_clock, sdio_in, oscillator_select,
             multichip_align_in, keying_direction, powerdown_pin,
             register_update_strobe, three_wire_mode, sync_slave_mode}),
    .q     (pin_s)
  );

  assign {hw_rst_s, cs_s, sclk_s, sdio_s, osc_s, align_s, key_s, pd_s,
          upd_s, three_wire_s, slave_s} = pin_s;

  always_ff @(posedge mclk or negedge sp_rst_n) begin
    if (!sp_rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div        <= 1'b0;
      align_prev <= 1'b0;
    end else if (hw_rst_s) begin
      div        <= 1'b0;
      align_prev <= 1'b0;
    end else begin
      align_prev <= align_s;
      if (align_rise) begin
        div <= 1'b1;
      end else begin
        div <= ~div;
      end
    end
  end

  assign align_rise      = slave_s & align_s & ~align_prev;
  assign sync_en         = ~div & ~align_rise;
  assign core_timing_out = div;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upd_ct <= 1'b0;
    end else if (hw_rst_s) begin
      upd_ct <= 1'b0;
    end else if (sync_en) begin
      upd_ct <= upd_s;
    end
  end

  assign upd_pulse = sync_en & upd_s & ~upd_ct;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      keying_ramp_up <= 1'b0;
    end else if (hw_rst_s) begin
      keying_ramp_up <= 1'b0;
    end else if (sync_en && act_q[`SCP_REG_CTRL][`SCP_CTRL_KEY_EN]) begin
      keying_ramp_up <= key_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'b0;
      osc_bypass <= 1'b1;
    end else begin
      osc_enable <= osc_s;
      osc_bypass <= ~osc_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_down <= 1'b0;
    end else if (hw_rst_s) begin
      power_down <= 1'b0;
    end else begin
      power_down <= pd_s | act_q[`SCP_REG_CTRL][`SCP_CTRL_PWRDN];
    end
  end

  always_ff @(posedge mclk or negedge sp_rst_n) begin
    if (!sp_rst_n) begin
      state    <= SCP_IDLE;
      cnt      <= '0;
      instr    <= 8'h00;
      shin     <= `SCP_BUF_RST;
      rd_shift <= `SCP_BUF_RST;
      sdo_q    <= 1'b0;
      wr_en    <= 1'b0;
      wr_addr  <= `SCP_REG_CTRL;
      wr_data  <= `SCP_BUF_RST;
    end else begin
      wr_en <= 1'b0;
      if (hw_rst_s || cs_s) begin
        state <= SCP_IDLE;
        cnt   <= '0;
      end else if (sclk_rise) begin
        case (state)
          SCP_IDLE, SCP_INSTR: begin
            instr <= {instr[6:0], sdio_s};
            if (cnt == `SCP_INSTR_LAST) begin
              state    <= SCP_DATA;
              cnt      <= '0;
              rd_shift <= act_q[{instr[0], sdio_s}];
            end else begin
              state <= SCP_INSTR;
              cnt   <= `SCP_CNT_W'(cnt + 1'b1);
            end
          end
          SCP_DATA: begin
            shin <= {shin[30:0], sdio_s};
            if (cnt == `SCP_DATA_LAST) begin
              wr_en   <= ~instr[`SCP_RW_BIT];
              wr_addr <= instr[`SCP_AW-1:0];
              wr_data <= {shin[30:0], sdio_s};
              state   <= SCP_INSTR;
              cnt     <= '0;
            end else begin
              cnt <= `SCP_CNT_W'(cnt + 1'b1);
            end
          end
          default: begin
            state <= SCP_IDLE;
          end
        endcase
      end else if (sclk_fall && state == SCP_DATA && instr[`SCP_RW_BIT]) begin
        sdo_q    <= rd_shift[31];
        rd_shift <= {rd_shift[30:0], 1'b0};
      end
    end
  end

  assign serial_out = sdo_q;
  assign sdio_out   = sdo_q;
  assign sdio_oe    = ~three_wire_s & ~cs_s & (state == SCP_DATA) & instr[`SCP_RW_BIT];

  genvar g;
  generate
    for (g = 0; g < `SCP_NREG; g++) begin : g_reg
      localparam scp_word_t ACT_INIT = (g == 0) ? `SCP_CTRL_ACT_RST : `SCP_ACT_RST;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          buf_q[g] <= `SCP_BUF_RST;
        end else if (hw_rst_s) begin
          buf_q[g] <= `SCP_BUF_RST;
        end else if (wr_en && wr_addr == `SCP_AW'(g)) begin
          buf_q[g] <= wr_data;
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          act_q[g] <= ACT_INIT;
        end else if (hw_rst_s) begin
          act_q[g] <= ACT_INIT;
        end else if (upd_pulse) begin
          act_q[g] <= buf_q[g];
        end
      end
    end
  endgenerate

  assign freq_word   = act_q[`SCP_REG_FREQ];
  assign phase_clear = act_q[`SCP_REG_CTRL][`SCP_CTRL_CLR];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_acc <= `SCP_ACT_RST;
      phase_out <= '0;
      amp_out   <= '0;
    end else if (hw_rst_s) begin
      phase_acc <= `SCP_ACT_RST;
      phase_out <= '0;
      amp_out   <= '0;
    end else begin
      phase_acc <= phase_clear ? `SCP_ACT_RST : scp_word_t'(phase_acc + freq_word);
      phase_out <= scp_ph_t'(phase_acc[31:`SCP_PH_LSB] + act_q[`SCP_REG_PHASE][`SCP_PH_W-1:0]);
      amp_out   <= act_q[`SCP_REG_AMP][`SCP_PH_W-1:0];
    end
  end

  // Checks; the whole latency budget is far inside both required limits.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || hw_rst_s);

  sequence s_strobe_seen;
    $rose(upd_s);
  endsequence
  sequence s_copied;
    ##[0:2] upd_pulse ##2 (amp_out == $past(buf_q[`SCP_REG_AMP][`SCP_PH_W-1:0], 2));
  endsequence

  chk_update_copy: assert property (upd_pulse |=> freq_word == $past(buf_q[`SCP_REG_FREQ]))
    else $error("Active frequency not loaded from buffer on update.");
  chk_update_latency: assert property (s_strobe_seen |-> s_copied)
    else $error("Update strobe not applied within latency.");
  chk_osc_select: assert property ($changed(osc_s) |=> osc_enable == $past(osc_s) && osc_bypass != osc_enable)
    else $error("Oscillator enable does not follow select pin.");
  chk_reset_init: assert property (@(posedge mclk) disable iff (!rst_n) hw_rst_s |=> phase_clear && freq_word == `SCP_ACT_RST)
    else $error("Hardware reset did not restore initial state.");
  chk_abort_idle: assert property (@(posedge mclk) disable iff (!arst_n) !sp_rst_n |-> state == SCP_IDLE && !wr_en)
    else $error("Serial controller active during abort.");
  chk_three_wire_quiet: assert property (three_wire_s |-> !sdio_oe)
    else $error("Shared data pin driven in three-wire mode.");
  chk_cs_release: assert property (@(posedge mclk) disable iff (!sp_rst_n) cs_s |=> state == SCP_IDLE && !sdio_oe)
    else $error("Serial traffic handled while deselected.");
  chk_timing_toggle: assert property (!align_rise |=> core_timing_out != $past(core_timing_out))
    else $error("Timing clock output did not toggle.");
  chk_key_sample: assert property (sync_en && act_q[`SCP_REG_CTRL][`SCP_CTRL_KEY_EN] |=> keying_ramp_up == $past(key_s))
    else $error("Keying direction not sampled on timing edge.");
  chk_clear_hold: assert property (phase_clear [*2] |=> phase_acc == `SCP_ACT_RST)
    else $error("Phase accumulator ran while cleared.");
  chk_read_falling: assert property (@(posedge mclk) disable iff (!sp_rst_n) $changed(sdo_q) |-> $past(sclk_fall))
    else $error("Read data changed outside a falling serial clock.");
endmodule
`default_nettype wire

// file: tb/scp_host.sv
// Host controller model that drives the serial port pins of the synthesizer.
`timescale 1ns/100ps
`default_nettype none
module scp_host (
  input  wire logic mclk,
  input  wire logic sdio_wire,
  input  wire logic serial_out,
  input  wire logic three_wire_mode,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      host_d
);
  logic host_oe;

  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b0;
    host_d        = 1'b0;
    host_oe       = 1'b1;
  end

  task automatic half(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // framed transfer, MSB first.
  // The serial clock rests low outside frames; data moves only while it is low.
  task automatic xfer(input logic rd, input logic [1:0] adr, input logic [31:0] wd,
                      input int nbits, input logic csn, output logic [31:0] rdat);
    logic [39:0] sh;
    int          hp;
    sh = {rd, 5'h00, adr, wd};
    hp = rd ? 50 : 8;
    rdat = 32'h0;
    chip_select_n = csn;
    for (int i = 0; i < nbits; i++) begin
      if (host_oe) begin
        host_d = sh[39-i];
      end else begin
        // A released line must not keep showing the last bit.
        host_d = ~host_d;
      end
      half(hp);
      serial_clock = 1'b1;
      if (i >= 8) begin
        rdat = {rdat[30:0], three_wire_mode ? serial_out : sdio_wire};
      end
      if (rd && i == 7 && !three_wire_mode) begin
        host_oe = 1'b0;
      end
      half(hp);
      serial_clock = 1'b0;
    end
    if (nbits == 40) begin
      half(hp);
      chip_select_n = 1'b1;
      host_oe = 1'b1;
      half(hp);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial control port and pin logic.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) chk(32'(a), 32'(e))
module testbench;
  logic               mclk, arst_n, hw_reset, abort, three_wire, strobe;
  logic               osc_sel, key_dir, pdn, sdio_out, sdio_oe, serial_out;
  logic               osc_en, osc_byp, ctime, ramp_up, pwr_dn, ph_clr;
  logic               csn, sclk, host_d, oe_seen;
  logic               slave, align;
  wire                sdio_wire;
  scp_pkg::scp_word_t freq;
  scp_pkg::scp_ph_t   amp, ph;
  int                 err_total, n_compared;

  assign sdio_wire = (sdio_oe === 1'b1) ? sdio_out : host_d;

  scp_top scp_top_inst (.mclk(mclk), .arst_n(arst_n), .hw_reset(hw_reset),
    .serial_port_abort(abort), .chip_select_n(csn), .serial_clock(sclk),
    .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out(serial_out),
    .three_wire_mode(three_wire), .register_update_strobe(strobe),
    .oscillator_select(osc_sel), .osc_enable(osc_en), .osc_bypass(osc_byp),
    .multichip_align_in(align), .sync_slave_mode(slave), .core_timing_out(ctime),
    .keying_direction(key_dir), .keying_ramp_up(ramp_up), .powerdown_pin(pdn),
    .power_down(pwr_dn), .freq_word(freq), .phase_out(ph), .amp_out(amp),
    .phase_clear(ph_clr));

  scp_host scp_host_inst (.mclk(mclk), .sdio_wire(sdio_wire), .serial_out(serial_out),
    .three_wire_mode(three_wire), .chip_select_n(csn), .serial_clock(sclk),
    .host_d(host_d));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (sdio_oe === 1'b1) oe_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [1:0] adr, input logic [31:0] d);
    logic [31:0] r;
    scp_host_inst.xfer(1'b0, adr, d, 40, 1'b0, r);
  endtask

  // strobe moves just after a clock edge.
  task automatic upd();
    strobe = 1'b1;
    cyc(24);
    strobe = 1'b0;
    cyc(8);
  endtask

  task automatic t_timing();
    logic a;
    a = ctime;
    cyc(1);
    `CHK(ctime, !a);
    cyc(1);
    `CHK(ctime, a);
  endtask

  task automatic t_update();
    wr(2'h1, 32'hA5A53C3C);
    wr(2'h3, 32'h00002FED);
    wr(2'h0, 32'h00000000);
    cyc(30);
    `CHK(freq, 32'h0);
    `CHK(ph_clr, 1'b1);
    strobe = 1'b1;
    cyc(16);
    `CHK(amp, 14'h2FED);
    cyc(8);
    `CHK(freq, 32'hA5A53C3C);
    `CHK(ph_clr, 1'b0);
    strobe = 1'b0;
    cyc(8);
  endtask

  task automatic rd_chk(input logic tw, input logic [1:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    three_wire = tw;
    oe_seen = 1'b0;
    scp_host_inst.xfer(1'b1, adr, 32'h0, 40, 1'b0, r);
    `CHK(r, exp);
    `CHK(oe_seen, !tw);
  endtask

  task automatic t_cs_abort();
    logic [31:0] r;
    scp_host_inst.xfer(1'b0, 2'h1, 32'hFFFF0000, 40, 1'b1, r);
    upd();
    `CHK(freq, 32'hA5A53C3C);
    scp_host_inst.xfer(1'b0, 2'h1, 32'h11111111, 20, 1'b0, r);
    abort = 1'b1;
    cyc(4);
    abort = 1'b0;
    cyc(6);
    `CHK(freq, 32'hA5A53C3C);
    scp_host_inst.xfer(1'b0, 2'h1, 32'h0F0F1234, 40, 1'b0, r);
    upd();
    `CHK(freq, 32'h0F0F1234);
  endtask

  task automatic t_pins();
    osc_sel = 1'b1;
    pdn = 1'b1;
    cyc(6);
    `CHK({osc_en, osc_byp}, 2'b10);
    `CHK(pwr_dn, 1'b1);
    osc_sel = 1'b0;
    pdn = 1'b0;
    cyc(6);
    `CHK({osc_en, osc_byp}, 2'b01);
    `CHK(pwr_dn, 1'b0);
    wr(2'h0, 32'h00000006);
    upd();
    `CHK(pwr_dn, 1'b1);
    key_dir = 1'b1;
    cyc(8);
    `CHK(ramp_up, 1'b1);
    key_dir = 1'b0;
    cyc(8);
    `CHK(ramp_up, 1'b0);
  endtask

  // Align is raised while the timing clock is high, so its own toggling would show low at E3.
  task automatic t_align();
    slave = 1'b1;
    cyc(4);
    if (!ctime) begin
      cyc(1);
    end
    align = 1'b1;
    cyc(3);
    `CHK(ctime, 1'b1);
    cyc(1);
    `CHK(ctime, 1'b0);
    align = 1'b0;
    slave = 1'b0;
    cyc(4);
  endtask

  task automatic t_hwreset();
    hw_reset = 1'b1;
    cyc(6);
    hw_reset = 1'b0;
    cyc(6);
    `CHK(freq, 32'h0);
    `CHK(amp, 14'h0);
    `CHK({ph_clr, pwr_dn}, 2'b10);
    `CHK(ph, 14'h0);
    wr(2'h2, 32'h00001ABC);
    upd();
    `CHK(ph, 14'h1ABC);
    `CHK(ph_clr, 1'b0);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    err_total = 0;
    n_compared = 0;
    oe_seen = 1'b0;
    hw_reset = 1'b0;
    abort = 1'b0;
    key_dir = 1'b0;
    three_wire = 1'b1;
    strobe = 1'b0;
    osc_sel = 1'b0;
    pdn = 1'b0;
    slave = 1'b0;
    align = 1'b0;
    arst_n = 1'b0;
    cyc(12);
    arst_n = 1'b1;
    cyc(6);
    `CHK({osc_byp, ph_clr}, 2'b11);
    `CHK(freq, 32'h0);
    t_timing();
    t_update();
    rd_chk(1'b1, 2'h1, 32'hA5A53C3C);
    rd_chk(1'b0, 2'h3, 32'h00002FED);
    t_cs_abort();
    t_pins();
    t_align();
    t_hwreset();
    test_done();
  end

  // Watchdog: a hang counts as a mismatch and ends the run.
  initial begin
    #400000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
